// [common/sfrpe_consts.svh]
/*
 * Constants of the serial flash command sequencer: command codes, array geometry and
 * the durations of the self-timed cycles.
 * Assumes the system clock runs at the rate given below and the array holds 1 Mbit.
 */
`ifndef SFRPE_CONSTS_SVH
`define SFRPE_CONSTS_SVH

`define SFRPE_CMD_WRITE_ENABLE 8'h06
`define SFRPE_CMD_WRITE_DISABLE 8'h04
`define SFRPE_CMD_READ 8'h03
`define SFRPE_CMD_FAST_READ 8'h0b
`define SFRPE_CMD_PAGE_PROGRAM 8'h02
`define SFRPE_CMD_SECTOR_ERASE 8'hd8
`define SFRPE_CMD_BULK_ERASE 8'hc7
`define SFRPE_CMD_POWERDOWN 8'hb9
`define SFRPE_CMD_RELEASE 8'hab

`define SFRPE_MEM_AW 17
`define SFRPE_MEM_TOP 17'h1ffff
`define SFRPE_SECTOR_MASK 17'h07fff
`define SFRPE_PAGE_MASK 17'h000ff
`define SFRPE_ERASED 8'hff

`define SFRPE_READ_HDR_BYTES 4'h3
`define SFRPE_FAST_HDR_BYTES 4'h4
`define SFRPE_ERASE_HDR_BYTES 4'h4
`define SFRPE_MIN_PROGRAM_BYTES 4'h5

`define SFRPE_SYS_CLK_MHZ 100
`define SFRPE_PAGE_PROGRAM_TIME_US 5000
`define SFRPE_SECTOR_ERASE_TIME_US 3000000
`define SFRPE_BULK_ERASE_TIME_US 10000000
`define SFRPE_POWERDOWN_ENTRY_DELAY_NS 3000
`define SFRPE_POWERDOWN_ENTRY_CYCLES \
   ((`SFRPE_POWERDOWN_ENTRY_DELAY_NS * `SFRPE_SYS_CLK_MHZ + 999) / 1000)

`endif

// [common/sfrpe_pkg.sv]
/*
 * Types of the serial flash command sequencer.
 * Assumes sfrpe_consts.svh supplies the numeric constants.
 */
package sfrpe_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WORK = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_PDWAIT = 4'b1000
   } sfrpe_state_type;

   typedef struct packed {
      logic [7:0] cmd;
      logic [23:0] addr;
      logic [3:0] bytes;
      logic [2:0] bits;
   } sfrpe_frame_type;

endpackage : sfrpe_pkg

// [rtl/sfrpe_flash.sv]
/*
 * Command sequencer of a serial flash: read, fast read, page program, sector and bulk
 * erase, write enable/disable and deep power-down, with the array behind it.
 * Assumes an SPI host on link_clk (mode 0, clock idle outside frames) and a free
 * running sys_clk; sys_rst is the power-on reset.
 */
//
// Contract
// RL1 - Read: command and 3 address bytes sampled on rise, data driven on fall.
// RL2 - Read address increments per byte and wraps from top to zero.
// RL3 - Read ends when select rises, even mid byte.
// RL4 - Reads and power-down rejected while a self-timed cycle runs.
// RL5 - Fast read takes one dummy byte after the address.
// RL6 - Program and erases need the write enable latch set beforehand.
// RL7 - Host keeps select low across command, address and data.
// RL8 - Program data past page end wraps to the page start.
// RL9 - Over 256 data bytes, only the last 256 are programmed.
// RL10 - Under 256 bytes, only addressed bytes of the page change.
// RL11 - Programming only clears bits; erase sets them.
// RL12 - Program runs only if select rises on a data byte boundary.
// RL13 - Valid program or erase starts timed cycle; busy set; latch cleared.
// RL14 - Program to a protected page is not executed.
// RL15 - Sector erase sets every byte of the addressed sector to FFh.
// RL16 - Sector erase runs only if select rises after third address byte.
// RL17 - Erase of a protected sector is not executed.
// RL18 - Bulk erase and power-down run only if select rises after command.
// RL19 - Bulk erase runs only when all protect bits are zero.
// RL20 - In power-down, write, program and erase commands are ignored.
// RL21 - Power-down is entered only after the entry delay.
// RL22 - Host sends only release while powered down.
// RL23 - In power-down only release or signature command wakes the device.
// RL24 - Without the write enable latch no program or erase is accepted.
// RL25 - Select rising before the address completes discards the command.
`timescale 1ns/1ps
`include "sfrpe_consts.svh"

module sfrpe_flash #(
   parameter int unsigned PAGE_PROGRAM_CYCLES =
      `SFRPE_PAGE_PROGRAM_TIME_US * `SFRPE_SYS_CLK_MHZ,
   parameter int unsigned SECTOR_ERASE_CYCLES =
      `SFRPE_SECTOR_ERASE_TIME_US * `SFRPE_SYS_CLK_MHZ,
   parameter int unsigned BULK_ERASE_CYCLES =
      `SFRPE_BULK_ERASE_TIME_US * `SFRPE_SYS_CLK_MHZ
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic select_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_out_en,
   input wire logic protect_level_bit2,
   input wire logic protect_level_bit1,
   input wire logic protect_level_bit0,
   output logic busy_flag,
   output logic write_enable_latch,
   output logic deep_powerdown
);

   localparam int unsigned PD_CYCLES = `SFRPE_POWERDOWN_ENTRY_CYCLES;

   // Array and page buffer. The array is written only by the sys_clk side during a
   // timed cycle, and the link side reads it only while no cycle runs, so the read
   // path sees static contents. The page buffer is the mirror case.
   logic [7:0] mem [0:`SFRPE_MEM_TOP];
   logic [7:0] page_buf [0:255];
   logic [255:0] page_vld_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Link side, clocked by the host's serial clock.

   logic frame_rst, in_frame_q, frame_tog_q, byte_done, rd_start, pg_data;
   sfrpe_pkg::sfrpe_frame_type lk_q;
   logic [7:0] shift_q, pg_ptr_q, out_sh_q, shift_src, new_byte;
   logic blk_meta_q, blk_sync_q, rd_active_q, dout_q, dout_en_q;
   logic [`SFRPE_MEM_AW-1:0] rd_addr_q, rd_start_addr;
   logic [2:0] cur_bits;
   logic [3:0] cur_bytes;
   // Driven on sys_clk; the link side reads it only through the two-flop synchroniser.
   logic reads_blocked_q;

   // Select high clears frame state at once; the clock may not run then.
   assign frame_rst = sys_rst | select_n;
   assign cur_bits = in_frame_q ? lk_q.bits : 3'h0;
   assign cur_bytes = in_frame_q ? lk_q.bytes : 4'h0;
   assign shift_src = in_frame_q ? shift_q : 8'h00;
   assign new_byte = {shift_src[6:0], serial_data_in};
   assign byte_done = (cur_bits == 3'h7);
   assign rd_start = byte_done && !blk_sync_q && ( // see RL4
      (lk_q.cmd == `SFRPE_CMD_READ && cur_bytes == `SFRPE_READ_HDR_BYTES) || // see RL1
      (lk_q.cmd == `SFRPE_CMD_FAST_READ && cur_bytes == `SFRPE_FAST_HDR_BYTES)); // see RL5
   assign rd_start_addr = (cur_bytes == `SFRPE_READ_HDR_BYTES) ?
      {lk_q.addr[16:8], new_byte} : lk_q.addr[16:0];
   assign pg_data = byte_done && !blk_sync_q && (cur_bytes >= `SFRPE_ERASE_HDR_BYTES)
      && (lk_q.cmd == `SFRPE_CMD_PAGE_PROGRAM);

   always_ff @(posedge link_clk or posedge frame_rst) begin
      if (frame_rst) begin
         in_frame_q <= 1'b0;
      end else begin
         in_frame_q <= 1'b1;
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk_q <= '0;
         shift_q <= 8'h00;
         frame_tog_q <= 1'b0;
      end else begin
         lk_q.bits <= cur_bits + 3'h1;
         shift_q <= new_byte;
         if (!in_frame_q) begin
            frame_tog_q <= ~frame_tog_q;
         end
         if (byte_done) begin
            if (cur_bytes != 4'hf) begin
               lk_q.bytes <= cur_bytes + 4'h1;
            end
            unique case (cur_bytes)
               4'h0: lk_q.cmd <= new_byte;
               4'h1: lk_q.addr[23:16] <= new_byte;
               4'h2: lk_q.addr[15:8] <= new_byte;
               4'h3: lk_q.addr[7:0] <= new_byte;
               default: ;
            endcase
         end else if (!in_frame_q) begin
            lk_q.bytes <= 4'h0;
         end
      end
   end

   // Page buffer fill: the pointer stays eight bits wide, so it wraps inside the page
   // and a later byte simply overwrites the one sent 256 bytes before.
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pg_ptr_q <= 8'h00;
         page_vld_q <= '0;
      end else begin
         // Only a program frame that may run clears the marks: a frame refused during a
         // cycle must leave the page that the cycle is still writing intact.
         if (byte_done && cur_bytes == `SFRPE_READ_HDR_BYTES && !blk_sync_q
               && lk_q.cmd == `SFRPE_CMD_PAGE_PROGRAM) begin
            page_vld_q <= '0; // see RL4
         end
         if (byte_done && cur_bytes == `SFRPE_READ_HDR_BYTES) begin
            pg_ptr_q <= new_byte;
         end else if (pg_data) begin
            pg_ptr_q <= pg_ptr_q + 8'h01; // see RL8
            page_vld_q[pg_ptr_q] <= 1'b1; // see RL9 see RL10
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (pg_data) begin
         page_buf[pg_ptr_q] <= new_byte; // see RL9
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blk_meta_q <= 1'b1;
         blk_sync_q <= 1'b1;
      end else begin
         blk_meta_q <= reads_blocked_q;
         blk_sync_q <= blk_meta_q;
      end
   end

   always_ff @(posedge link_clk or posedge frame_rst) begin
      if (frame_rst) begin
         rd_active_q <= 1'b0; // see RL3
      end else if (rd_start) begin
         rd_active_q <= 1'b1;
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_addr_q <= '0;
         out_sh_q <= 8'h00;
      end else if (rd_start) begin
         out_sh_q <= mem[rd_start_addr];
         rd_addr_q <= rd_start_addr + 17'h00001;
      end else if (rd_active_q && byte_done) begin
         out_sh_q <= mem[rd_addr_q];
         rd_addr_q <= rd_addr_q + 17'h00001; // see RL2
      end else begin
         out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
   end

   always_ff @(negedge link_clk or posedge frame_rst) begin
      if (frame_rst) begin
         dout_q <= 1'b0;
         dout_en_q <= 1'b0; // see RL3
      end else begin
         dout_q <= out_sh_q[7] & rd_active_q; // see RL1
         dout_en_q <= rd_active_q;
      end
   end

   assign serial_data_out = dout_q;
   assign serial_data_out_en = dout_en_q;

   ////////////////////////////////////////////////////////////////////////////////
   // System side: frame end detection and crossing.

   logic sel_meta_q, sel_sync_q, sel_prev_q, tog_meta_q, tog_sync_q, tog_seen_q, frame_end;
   logic [2:0] prot_meta_q, prot_q;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_meta_q <= 1'b1;
         sel_sync_q <= 1'b1;
         sel_prev_q <= 1'b1;
         tog_meta_q <= 1'b0;
         tog_sync_q <= 1'b0;
         tog_seen_q <= 1'b0;
         prot_meta_q <= 3'h0;
         prot_q <= 3'h0;
      end else begin
         sel_meta_q <= select_n;
         sel_sync_q <= sel_meta_q;
         sel_prev_q <= sel_sync_q;
         tog_meta_q <= frame_tog_q;
         tog_sync_q <= tog_meta_q;
         prot_meta_q <= {protect_level_bit2, protect_level_bit1, protect_level_bit0};
         prot_q <= prot_meta_q;
         if (sel_sync_q && !sel_prev_q) begin
            tog_seen_q <= tog_sync_q;
         end
      end
   end

   // The toggle tells a frame with clock edges from a bare select pulse, which must
   // not replay the previous command. The frame record is quiet once select is high.
   assign frame_end = sel_sync_q && !sel_prev_q && (tog_sync_q != tog_seen_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode at frame end.

   function automatic logic is_protected(input logic [16:0] a, input logic [2:0] bp);
      unique case (bp)
         3'h0: is_protected = 1'b0;
         3'h1: is_protected = (a[16:15] == 2'h3);
         3'h2: is_protected = a[16];
         default: is_protected = 1'b1;
      endcase
   endfunction : is_protected

   sfrpe_pkg::sfrpe_state_type state_q;
   logic pd_q, wel_q, boundary, accept, start_pp, start_se, start_be, start_dp;
   logic do_wren, do_wrdi, do_release;

   assign boundary = (lk_q.bits == 3'h0);
   assign accept = frame_end && (state_q == sfrpe_pkg::ST_IDLE) && !pd_q; // see RL4 RL20
   assign start_pp = accept && wel_q && boundary // see RL6 see RL24
      && lk_q.cmd == `SFRPE_CMD_PAGE_PROGRAM
      && lk_q.bytes >= `SFRPE_MIN_PROGRAM_BYTES // see RL12 see RL25
      && !is_protected(lk_q.addr[16:0], prot_q); // see RL14
   assign start_se = accept && wel_q && boundary // see RL6 see RL24
      && lk_q.cmd == `SFRPE_CMD_SECTOR_ERASE
      && lk_q.bytes == `SFRPE_ERASE_HDR_BYTES // see RL16 see RL25
      && !is_protected(lk_q.addr[16:0], prot_q); // see RL17
   assign start_be = accept && wel_q && boundary // see RL6 see RL24
      && lk_q.cmd == `SFRPE_CMD_BULK_ERASE && lk_q.bytes == 4'h1 // see RL18
      && prot_q == 3'h0; // see RL19
   assign start_dp = accept && boundary && lk_q.cmd == `SFRPE_CMD_POWERDOWN
      && lk_q.bytes == 4'h1; // see RL18
   assign do_wren = accept && boundary && lk_q.cmd == `SFRPE_CMD_WRITE_ENABLE
      && lk_q.bytes == 4'h1;
   assign do_wrdi = accept && boundary && lk_q.cmd == `SFRPE_CMD_WRITE_DISABLE
      && lk_q.bytes == 4'h1;
   // Release and the signature read share one code; either wakes the device.
   assign do_release = frame_end && pd_q && lk_q.cmd == `SFRPE_CMD_RELEASE
      && lk_q.bytes != 4'h0; // see RL23

   ////////////////////////////////////////////////////////////////////////////////
   // Self-timed cycle.

   logic erase_q;
   logic [`SFRPE_MEM_AW-1:0] ptr_q;
   logic [`SFRPE_MEM_AW-1:0] end_q;
   logic [31:0] tmr_q;
   logic [31:0] dur_q;

   // The array update takes one byte per clock and the rest of the cycle time is held
   // as busy, so the timed figures must exceed the byte count of the operation.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= sfrpe_pkg::ST_IDLE;
         erase_q <= 1'b0;
         ptr_q <= '0;
         end_q <= '0;
         tmr_q <= 32'h0;
         dur_q <= 32'h0;
      end else begin
         unique case (state_q)
            sfrpe_pkg::ST_IDLE: begin
               tmr_q <= 32'h0;
               if (start_pp) begin
                  state_q <= sfrpe_pkg::ST_WORK; // see RL13
                  erase_q <= 1'b0;
                  ptr_q <= lk_q.addr[16:0] & ~`SFRPE_PAGE_MASK;
                  end_q <= lk_q.addr[16:0] | `SFRPE_PAGE_MASK;
                  dur_q <= PAGE_PROGRAM_CYCLES;
               end else if (start_se) begin
                  state_q <= sfrpe_pkg::ST_WORK; // see RL13
                  erase_q <= 1'b1;
                  ptr_q <= lk_q.addr[16:0] & ~`SFRPE_SECTOR_MASK; // see RL15
                  end_q <= lk_q.addr[16:0] | `SFRPE_SECTOR_MASK;
                  dur_q <= SECTOR_ERASE_CYCLES;
               end else if (start_be) begin
                  state_q <= sfrpe_pkg::ST_WORK; // see RL13
                  erase_q <= 1'b1;
                  ptr_q <= '0;
                  end_q <= `SFRPE_MEM_TOP;
                  dur_q <= BULK_ERASE_CYCLES;
               end else if (start_dp) begin
                  state_q <= sfrpe_pkg::ST_PDWAIT;
               end
            end
            sfrpe_pkg::ST_WORK: begin
               tmr_q <= tmr_q + 32'h1;
               ptr_q <= ptr_q + 17'h00001;
               if (ptr_q == end_q) begin
                  state_q <= sfrpe_pkg::ST_HOLD;
               end
            end
            sfrpe_pkg::ST_HOLD: begin
               tmr_q <= tmr_q + 32'h1;
               if (tmr_q + 32'h1 >= dur_q) begin
                  state_q <= sfrpe_pkg::ST_IDLE; // see RL13
               end
            end
            sfrpe_pkg::ST_PDWAIT: begin
               tmr_q <= tmr_q + 32'h1;
               if (tmr_q + 32'h1 >= PD_CYCLES) begin
                  state_q <= sfrpe_pkg::ST_IDLE; // see RL21
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (state_q == sfrpe_pkg::ST_WORK) begin
         if (erase_q) begin
            mem[ptr_q] <= `SFRPE_ERASED; // see RL15 see RL19
         end else if (page_vld_q[ptr_q[7:0]]) begin
            mem[ptr_q] <= mem[ptr_q] & page_buf[ptr_q[7:0]]; // see RL11 see RL10
         end
      end
   end

   // The latch drops as the cycle starts, which is before it completes.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wel_q <= 1'b0;
      end else if (start_pp || start_se || start_be || do_wrdi) begin
         wel_q <= 1'b0; // see RL13
      end else if (do_wren) begin
         wel_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pd_q <= 1'b0;
      end else if (state_q == sfrpe_pkg::ST_PDWAIT && tmr_q + 32'h1 >= PD_CYCLES) begin
         pd_q <= 1'b1; // see RL21
      end else if (do_release) begin
         pd_q <= 1'b0; // see RL23
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reads_blocked_q <= 1'b1;
      end else begin
         reads_blocked_q <= (state_q != sfrpe_pkg::ST_IDLE) || pd_q || start_pp
            || start_se || start_be || start_dp; // see RL4 see RL20
      end
   end

   assign busy_flag = (state_q == sfrpe_pkg::ST_WORK) || (state_q == sfrpe_pkg::ST_HOLD);
   assign write_enable_latch = wel_q;
   assign deep_powerdown = pd_q;

endmodule : sfrpe_flash

// [verification/sfrpe_monitor.sv]
/* Checker of the flash sequencer, bound to sfrpe_flash from tb.
   Assumes it sees only the top module's ports, all sampled on sys_clk. */
`timescale 1ns/1ps
module sfrpe_monitor #(
   parameter int unsigned PAGE_PROGRAM_CYCLES = 400
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic select_n,
   input wire logic serial_data_out_en,
   input wire logic busy_flag,
   input wire logic write_enable_latch,
   input wire logic deep_powerdown
);
   logic [8:0] desel_cnt_q;
   logic [17:0] busy_cnt_q;
   logic blocked_q;
   // The blocked flag is taken while deselected, so a frame is judged by the state it met.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blocked_q <= 1'b0;
      end else if (select_n) begin
         blocked_q <= busy_flag | deep_powerdown;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         desel_cnt_q <= 9'h000;
      end else if (!select_n) begin
         desel_cnt_q <= 9'h000;
      end else if (desel_cnt_q != 9'h1ff) begin
         desel_cnt_q <= desel_cnt_q + 9'h001;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt_q <= 18'h00000;
      end else begin
         busy_cnt_q <= busy_flag ? busy_cnt_q + 18'h00001 : 18'h00000;
      end
   end
   default clocking mon_cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   property p_release;
      select_n |-> !serial_data_out_en;
   endproperty
   a_release: assert property (p_release) else $error("output enabled while deselected");
   property p_reject;
      !select_n && blocked_q |-> !serial_data_out_en;
   endproperty
   a_reject: assert property (p_reject) else $error("read answered while busy");
   property p_pd_quiet;
      deep_powerdown |-> !serial_data_out_en;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("output in power-down");
   property p_wel_clr;
      $rose(busy_flag) |-> ##[0:2] !write_enable_latch;
   endproperty
   a_wel_clr: assert property (p_wel_clr) else $error("latch kept in cycle");
   property p_wel_need;
      $rose(busy_flag) |-> $past(write_enable_latch) || $past(write_enable_latch, 3);
   endproperty
   a_wel_need: assert property (p_wel_need) else $error("cycle without latch");
   property p_busy_len;
      $fell(busy_flag) |-> busy_cnt_q + 2 >= PAGE_PROGRAM_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy cycle too short");
   property p_busy_desel;
      $rose(busy_flag) |-> select_n && $past(select_n);
   endproperty
   a_busy_desel: assert property (p_busy_desel) else $error("cycle began mid frame");
   property p_pd_delay;
      $rose(deep_powerdown) |-> desel_cnt_q >= 9'h12c && !busy_flag;
   endproperty
   a_pd_delay: assert property (p_pd_delay) else $error("power-down entered early");
   property p_wel_set;
      $rose(write_enable_latch) |-> select_n && !busy_flag && !deep_powerdown;
   endproperty
   a_wel_set: assert property (p_wel_set) else $error("latch set when barred");
endmodule : sfrpe_monitor

// [verification/sfrpe_host.sv]
/* Model of the host link controller: mode 0, 6 ns link clock only within frames.
   Assumes the bench calls xfer and keeps frames apart by its closing wait. */
`timescale 1ns/1ps
module sfrpe_host (
   input wire logic sys_clk,
   output logic link_clk,
   output logic select_n,
   output logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_out_en
);
   initial begin
      link_clk = 1'b0;
      select_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // Extra bits (xb) end a frame off a byte boundary; they carry no meaning.
   task automatic xfer(input logic [7:0] tx[$], input int xb, input int nrd,
      output logic [7:0] rx[$], output logic en_seen);
      logic [7:0] b;
      int nb;
      rx = {};
      en_seen = 1'b0;
      nb = tx.size() * 8;
      b = 8'h00;
      @(negedge sys_clk);
      select_n = 1'b0;
      #2.3;
      for (int i = 0; i < nb + xb + nrd * 8; i++) begin
         serial_data_in = (i < nb) ? tx[i / 8][7 - i % 8] : ~serial_data_in;
         #3;
         b = {b[6:0], serial_data_out};
         en_seen = en_seen | serial_data_out_en;
         link_clk = 1'b1;
         #3;
         link_clk = 1'b0;
         if (i >= nb && nrd > 0 && (i - nb) % 8 == 7) begin
            rx.push_back(b);
         end
      end
      @(negedge sys_clk);
      select_n = 1'b1;
      serial_data_in = ~serial_data_in;
      repeat (6) @(negedge sys_clk);
   endtask : xfer
endmodule : sfrpe_host

// [verification/tb.sv]
/* Self-checking bench of the flash sequencer.
   Assumes sfrpe_host drives the link and sfrpe_monitor is bound below. */
`timescale 1ns/1ps
module tb;
   logic sys_clk, sys_rst, link_clk, select_n, serial_data_in, serial_data_out;
   logic serial_data_out_en, busy_flag, write_enable_latch, deep_powerdown, en_seen;
   logic [2:0] bp;
   logic [7:0] rx[$];
   logic [7:0] big[$];
   int mismatches, tests_run;
   sfrpe_flash #(.PAGE_PROGRAM_CYCLES(400), .SECTOR_ERASE_CYCLES(33000),
      .BULK_ERASE_CYCLES(132000)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link_clk(link_clk), .select_n(select_n), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
      .protect_level_bit2(bp[2]), .protect_level_bit1(bp[1]), .protect_level_bit0(bp[0]),
      .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
      .deep_powerdown(deep_powerdown));
   sfrpe_host host (.sys_clk(sys_clk), .link_clk(link_clk), .select_n(select_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_out_en(serial_data_out_en));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   task automatic run(input logic [7:0] tx[$], input int xb, input int nrd);
      host.xfer(tx, xb, nrd, rx, en_seen);
   endtask : run
   // Status is {busy, latch, power-down}, looked at n cycles after a frame.
   task automatic stat(input int n, input logic [2:0] exp);
      repeat (n) @(negedge sys_clk);
      chk("status", {5'h00, exp}, {5'h00, busy_flag, write_enable_latch, deep_powerdown});
   endtask : stat
   task automatic settle;
      int n;
      n = 0;
      repeat (8) @(negedge sys_clk);
      while (busy_flag !== 1'b0 && n < 40000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 40000) begin
         chk("busy_wait", 8'h00, 8'h01);
         test_done();
      end
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_erase;
      run({8'h06}, 0, 0);
      stat(8, 3'b010);
      run({8'hd8, 8'h00, 8'h04, 8'hd2}, 0, 0);
      stat(8, 3'b100);
      run({8'h03, 8'h00, 8'h00, 8'h00}, 0, 1);
      chk("busy_read_en", 8'h00, {7'h00, en_seen});
      run({8'hb9}, 0, 0);
      settle();
      stat(400, 3'b000);
      run({8'h03, 8'h00, 8'h00, 8'hfe}, 0, 1);
      chk("erased", 8'hff, rx[0]);
      $display("test erase done");
   endtask : t_erase
   task automatic t_prog;
      run({8'h06}, 0, 0);
      run({8'h02, 8'h00, 8'h00, 8'hfe, 8'ha5, 8'h3c, 8'h0f}, 0, 0);
      stat(8, 3'b100);
      settle();
      run({8'h0b, 8'h00, 8'h00, 8'hfe, 8'h00}, 0, 3);
      chk("fast_0", 8'ha5, rx[0]);
      chk("fast_1", 8'h3c, rx[1]);
      chk("untouched", 8'hff, rx[2]);
      run({8'h03, 8'h01, 8'hff, 8'hff}, 5, 3);
      chk("page_wrap", 8'h0f, rx[1]);
      chk("page_rest", 8'hff, rx[2]);
      run({8'h06}, 0, 0);
      run({8'h02, 8'h00, 8'h00, 8'hff, 8'hf0}, 0, 0);
      settle();
      run({8'h02, 8'h00, 8'h00, 8'hff, 8'h00}, 0, 0);
      stat(8, 3'b000);
      run({8'h03, 8'h00, 8'h00, 8'hff}, 0, 1);
      chk("and_bits", 8'h30, rx[0]);
      $display("test program done");
   endtask : t_prog
   task automatic t_long;
      big = {8'h02, 8'h00, 8'h02, 8'h00};
      for (int k = 0; k < 258; k++) begin
         big.push_back(k < 2 ? 8'h00 : 8'h3c);
      end
      run({8'h06}, 0, 0);
      run(big, 0, 0);
      settle();
      run({8'h03, 8'h00, 8'h02, 8'h00}, 0, 2);
      chk("last_256_a", 8'h3c, rx[0]);
      chk("last_256_b", 8'h3c, rx[1]);
      $display("test long program done");
   endtask : t_long
   task automatic t_cancel;
      run({8'h06}, 0, 0);
      run({8'h02, 8'h00, 8'h03, 8'h00, 8'h55}, 3, 0);
      stat(8, 3'b010);
      run({8'hd8, 8'h00, 8'h00}, 0, 0);
      stat(8, 3'b010);
      run({8'hd8, 8'h00, 8'h00, 8'h00}, 4, 0);
      stat(8, 3'b010);
      run({8'hc7}, 1, 0);
      stat(8, 3'b010);
      bp = 3'b001;
      run({8'hd8, 8'h01, 8'h80, 8'h00}, 0, 0);
      stat(8, 3'b010);
      run({8'h02, 8'h01, 8'hff, 8'h00, 8'h00}, 0, 0);
      stat(8, 3'b010);
      bp = 3'b010;
      run({8'hc7}, 0, 0);
      stat(8, 3'b010);
      bp = 3'b000;
      run({8'h03, 8'h00, 8'h03, 8'h00}, 0, 1);
      chk("cancelled", 8'hff, rx[0]);
      run({8'h04}, 0, 0);
      stat(8, 3'b000);
      $display("test cancel done");
   endtask : t_cancel
   task automatic t_pd;
      run({8'hb9}, 2, 0);
      stat(400, 3'b000);
      run({8'hb9}, 0, 0);
      stat(200, 3'b000);
      stat(150, 3'b001);
      run({8'h06}, 0, 0);
      stat(8, 3'b001);
      run({8'h03, 8'h00, 8'h00, 8'hfe}, 0, 1);
      chk("pd_read_en", 8'h00, {7'h00, en_seen});
      run({8'hab}, 0, 0);
      stat(8, 3'b000);
      run({8'h03, 8'h00, 8'h00, 8'hfe}, 0, 1);
      chk("woken_read", 8'ha5, rx[0]);
      $display("test power-down done");
   endtask : t_pd
   initial begin
      mismatches = 0;
      tests_run = 0;
      bp = 3'b000;
      sys_rst = 1'b1;
      repeat (20) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (5) @(negedge sys_clk);
      t_erase();
      t_prog();
      t_long();
      t_cancel();
      t_pd();
      test_done();
   end
endmodule : tb
bind sfrpe_flash sfrpe_monitor #(.PAGE_PROGRAM_CYCLES(PAGE_PROGRAM_CYCLES)) mon (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .select_n(select_n),
   .serial_data_out_en(serial_data_out_en), .busy_flag(busy_flag),
   .write_enable_latch(write_enable_latch), .deep_powerdown(deep_powerdown));
